/* File: common/cmr_pkg.sv */
// Constants and carrier types for the card machine ready and check logic.
// Assumes a single 100 MHz clock and a plain strobe-style register port.
// Function
// - Print start with no card at preprint is accepted but not performed.
// - Printer accepts 63 codes: blank 0x40, digits 0xf0-0xf9, letters, specials.
// - Card motion same with or without print; card halts at print, then stacks.
// - With level 6 enabled, either feed going ready requests an interrupt.
// - Stacker, covers, interlock, chip box, hand wheel, stop raise attention; blocks ready.
// - Attention drops both feeds from ready and raises summary I/O check.
// - Mispositioned card, covers opened running, or malfunction set feed check.
// - Feed check drops both ready states and raises summary I/O check.
// - Clutch, drum write/erase or timing pulse faults set machine check.
// - Machine check drops both ready states and raises summary I/O check.
// - Read error or invalid code sets read check; invalid code delivers 0x00.
// - Punch error sets punch check; read or punch check raises I/O check.
// - Read/punch checks clear by sense after start, check reset, or runout key.
// - Feed ready needs power, cards, no hopper/attention/feed/machine check, no stop.
// - Start sets ready feeds; run-in feeds one secondary and two primary cards.
// - Primary and secondary feed control operate independently; a hopper check on either feed drops both ready states.
// - Start restores feed ready after a corrected hopper check.
// - Card misfeed sets that hopper's check; clearing needs no runout.
// - Stop removes ready; running operations finish before the machine halts.
// - Hopper, print, adapter checks or no-op bit also raise I/O check.
package cmr_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_SENSE = 4'h2;
    localparam logic [3:0] ADDR_CMD = 4'h3;
    localparam logic [3:0] ADDR_CHAR = 4'h4;
    // Control register bits
    localparam int CTRL_INTEN = 0;
    // Command register bits (write one pulses)
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CHKRST = 2;
    localparam int CMD_RUNOUT = 3;
    localparam int CMD_SIO_PRINT = 4;
    localparam int CMD_SIO_PUNCH = 5;
    localparam int CMD_SENSE_RP = 6;
    localparam int CMD_SIO_READ = 7;
    localparam logic [7:0] CODE_BLANK = 8'h40;
    localparam logic [7:0] CODE_DIGIT_LO = 8'hf0;
    localparam logic [7:0] CODE_DIGIT_HI = 8'hf9;
    localparam logic [7:0] CODE_INVALID_DATA = 8'h00;
    localparam logic [1:0] RUNIN_PRI_CARDS = 2'h2;
    localparam logic [1:0] RUNIN_SEC_CARDS = 2'h1;

    typedef struct packed {
        logic attnCause;
        logic feedFault;
        logic machFault;
        logic readErr;
        logic punchErr;
        logic priMisfeed;
        logic secMisfeed;
        logic printChk;
        logic adapterChk;
    } cmr_fault_t;

    typedef struct packed {
        logic powerOn;
        logic priPreread;
        logic priHopper;
        logic secPreread;
        logic secHopper;
        logic lastCard;
        logic opBusy;
        logic prePrint;
    } cmr_mach_t;
endpackage

/* File: dv/cmr_pu_model.sv */
// Processing unit model: issues register writes and reads on the strobe port.
// Assumes the device answers a read in the cycle after the read strobe.
`timescale 1ns/1ps
module cmr_pu_model
(
    // Clock
    input wire logic clk,
    // Register port toward the device
    output logic [3:0] addr,
    output logic [7:0] wrData,
    output logic wrStb,
    output logic rdStb,
    input wire logic [7:0] rdData
);
    // ==========================================
    // Bus cycles
    initial
    begin
        addr = 4'h0;
        wrData = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
    end
    // One-cycle write; data inverted after so stale values never pass
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
        wrData <= ~d;
    endtask
    // Read data is taken only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the card machine ready and check logic.
// Assumes the processing unit model drives the register port.
`timescale 1ns/1ps
module tb_top;
    import cmr_pkg::*;
    logic clk, arst_n, wrStb, rdStb, invalidCode, irqReq, printGo, printCharOk;
    logic priReady, secReady, ioCheck, attention, machineHalt;
    logic [3:0] addr;
    logic [7:0] wrData, rdData, colData, printChar, storeData, d;
    logic [1:0] priFeedCount, secFeedCount;
    cmr_fault_t fault;
    cmr_mach_t mach;
    int error_cnt, checks_done, cycles, irqCnt, goCnt;
    logic [31:0] lfsr;

    cmr_ready_check cmr_ready_check_i (.clk, .arst_n, .addr, .wrData, .wrStb, .rdStb,
        .rdData, .fault, .mach, .invalidCode, .colData, .printChar, .priReady, .secReady,
        .ioCheck, .attention, .irqReq, .printGo, .printCharOk, .storeData, .machineHalt,
        .priFeedCount, .secFeedCount);
    cmr_pu_model cmr_pu_model_i (.clk, .addr, .wrData, .wrStb, .rdStb, .rdData);

    // ==========================================
    // Helpers
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Accepted print codes: blank, specials, letters, digits
    function automatic logic okChar(input logic [7:0] c);
        logic [3:0] lo;
        lo = c[3:0];
        case (c[7:4])
            4'h4: return c == 8'h40 || lo >= 4'ha;
            4'h5: return c == 8'h50 || lo >= 4'ha;
            4'h6: return c == 8'h60 || c == 8'h61 || lo >= 4'hb;
            4'h7: return lo >= 4'ha;
            4'hc, 4'hd: return lo >= 4'h1 && lo <= 4'h9;
            4'he: return lo >= 4'h2 && lo <= 4'h9;
            4'hf: return lo <= 4'h9;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        cmr_pu_model_i.rd(a, d);
        chk(what, exp, d & m);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c);
        cmr_pu_model_i.wr(ADDR_CMD, c);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================
    // Clock, monitors and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulses are counted at the edge, before that edge's updates land
    always @(posedge clk)
    begin
        irqCnt += (irqReq === 1'b1);
        goCnt += (printGo === 1'b1);
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ==========================================
    // Scenarios
    initial
    begin
        arst_n = 1'b0;
        fault = '0;
        mach = '0;
        invalidCode = 1'b0;
        colData = 8'h00;
        printChar = 8'h00;
        lfsr = 32'h0830;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        settle(1);
        chk("ready", 8'h00, {6'h0, secReady, priReady});
        rdChk("ctrl", ADDR_CTRL, 8'hff, 8'h00);
        rdChk("unmapped", 4'h9, 8'hff, 8'h00);
        mach <= 8'hf8;
        cmr_pu_model_i.wr(ADDR_CTRL, 8'h01);
        cmd(8'h01);
        #1;
        chk("feeds", {4'h0, RUNIN_PRI_CARDS, RUNIN_SEC_CARDS},
            {4'h0, priFeedCount, secFeedCount});
        settle(2);
        chk("ready", 8'h03, {6'h0, secReady, priReady});
        chk("feeds", 8'h00, {4'h0, priFeedCount, secFeedCount});
        chk("irq", 8'h01, irqCnt[7:0]);
        mach <= 8'hf0;
        settle(2);
        chk("ready", 8'h01, {6'h0, secReady, priReady});
        mach <= 8'hf8;
        cmd(8'h01);
        settle(2);
        chk("irq", 8'h02, irqCnt[7:0]);
        // Attention, feed check, machine check in turn
        for (int i = 0; i < 3; i++)
        begin
            fault <= 9'h100 >> i;
            settle(2);
            chk("ready", 8'h00, {6'h0, secReady, priReady});
            chk("iochk", 8'h01, {7'h0, ioCheck});
            chk("attn", {7'h0, i == 0}, {7'h0, attention});
            fault <= '0;
            if (i > 0)
                rdChk("sense", ADDR_SENSE, 8'h03, 8'h01 << (i - 1));
            cmd(8'h08);
            cmd(8'h01);
            settle(2);
            chk("ready", 8'h03, {6'h0, secReady, priReady});
        end
        fault <= 9'h020;
        settle(1);
        fault <= 9'h010;
        settle(1);
        fault <= '0;
        rdChk("sense", ADDR_SENSE, 8'h0c, 8'h0c);
        chk("iochk", 8'h01, {7'h0, ioCheck});
        cmd(8'h04);
        rdChk("sense", ADDR_SENSE, 8'h0c, 8'h00);
        fault <= 9'h010;
        settle(1);
        fault <= '0;
        cmd(8'h80);
        cmd(8'h40);
        rdChk("sense", ADDR_SENSE, 8'h0c, 8'h00);
        fault <= 9'h008;
        settle(2);
        fault <= '0;
        rdChk("status", ADDR_STATUS, 8'h07, 8'h04);
        cmd(8'h01);
        settle(2);
        chk("ready", 8'h03, {6'h0, secReady, priReady});
        cmd(8'h10);
        settle(2);
        chk("go", 8'h00, goCnt[7:0]);
        chk("iochk", 8'h01, {7'h0, ioCheck});
        cmd(8'h04);
        mach <= 8'hf9;
        cmd(8'h10);
        settle(2);
        chk("go", 8'h01, goCnt[7:0]);
        mach <= 8'hfb;
        cmd(8'h02);
        settle(2);
        chk("ready", 8'h00, {6'h0, secReady, priReady});
        chk("halt", 8'h00, {7'h0, machineHalt});
        mach <= 8'hf9;
        settle(2);
        chk("halt", 8'h01, {7'h0, machineHalt});
        // Random codes with digit and blank corners
        for (int i = 0; i < 300; i++)
        begin
            lfsr = step(lfsr);
            printChar <= (i % 3 == 0) ? 8'hf0 + lfsr[3:0] : (i == 1 ? 8'h40 : lfsr[7:0]);
            invalidCode <= lfsr[8];
            colData <= lfsr[23:16];
            settle(1);
            chk("char", {7'h0, okChar(printChar)}, {7'h0, printCharOk});
            chk("store", invalidCode ? 8'h00 : colData, storeData);
        end
        report_and_stop();
    end
endmodule

/* File: hdl/cmr_ready_check.sv */
// Ready, check and status logic of the card read/punch/print machine.
// Assumes machine sensors synchronous to clk and a strobe register port.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module cmr_ready_check
    import cmr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // Machine conditions
    input wire cmr_fault_t fault,
    input wire cmr_mach_t mach,
    input wire logic invalidCode,
    input wire logic [7:0] colData,
    input wire logic [7:0] printChar,
    // Outputs to machine and processing unit
    output logic priReady,
    output logic secReady,
    output logic ioCheck,
    output logic attention,
    output logic irqReq,
    output logic printGo,
    output logic printCharOk,
    output logic [7:0] storeData,
    output logic machineHalt,
    output logic [1:0] priFeedCount,
    output logic [1:0] secFeedCount
);
    typedef struct packed {
        logic intEn;
        logic priRdy;
        logic secRdy;
        logic stopped;
        logic stopPending;
        logic feedChk;
        logic machChk;
        logic readChk;
        logic punchChk;
        logic priHopChk;
        logic secHopChk;
        logic noOp;
        logic sioSeen;
        logic irq;
        logic print;
        logic [1:0] priFeed;
        logic [1:0] secFeed;
        logic [7:0] store;
        logic [7:0] rd;
    } cmr_state_t;

    cmr_state_t r;
    cmr_state_t next_r;
    logic priOk;
    logic secOk;
    logic chkBlock;
    logic sum;
    logic cmdStrobe;
    logic [7:0] cmd;

    // ========================================================
    // Combinational decode
    assign cmdStrobe = wrStb && (addr == ADDR_CMD);
    assign cmd = cmdStrobe ? wrData : 8'h00;
    assign attention = fault.attnCause;

    // Feed conditions, each feed judged on its own path; the checks and the stop
    // are folded in later, as they will stand after the coming edge
    assign priOk = mach.powerOn
        && (mach.lastCard || (mach.priPreread && mach.priHopper));
    assign secOk = mach.powerOn
        && (mach.lastCard || (mach.secPreread && mach.secHopper));

    // Summary check: any latched check or attention lights it at once
    assign sum = attention || r.feedChk || r.machChk || r.readChk || r.punchChk
        || r.priHopChk || r.secHopChk || fault.printChk || fault.adapterChk
        || r.noOp;

    // Accepted print codes: blank, digits, letters and specials
    always_comb
    begin
        printCharOk = 1'b0;
        if (printChar == CODE_BLANK) printCharOk = 1'b1;
        if (printChar >= CODE_DIGIT_LO && printChar <= CODE_DIGIT_HI) printCharOk = 1'b1;
        if (printChar[7:6] == 2'b11 && printChar[3:0] >= 4'h1 && printChar[3:0] <= 4'h9
            && printChar[5:4] != 2'b11 && !(printChar[5:4] == 2'b10 && printChar[3:0] == 4'h1))
            printCharOk = 1'b1;
        // Rows 5 to 7 of specials; row 6 starts one code later, so 0x6a is refused
        if (printChar[7:6] == 2'b01 && printChar[5:4] != 2'b00 && printChar[3:0] >= 4'ha
            && printChar != 8'h6a) printCharOk = 1'b1;
        if (printChar[7:6] == 2'b01 && printChar[5:4] == 2'b00 && printChar[3:0] >= 4'ha
            && printChar[3:0] <= 4'hf) printCharOk = 1'b1;
        if (printChar == 8'h50 || printChar == 8'h60 || printChar == 8'h61)
            printCharOk = 1'b1;
    end

    // ========================================================
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.irq = 1'b0;
        next_r.print = 1'b0;
        next_r.rd = 8'h00;
        // Config write
        if (wrStb && addr == ADDR_CTRL) next_r.intEn = wrData[CTRL_INTEN];
        // Stop: drop ready at once, halt only once the running op finishes
        if (cmd[CMD_STOP])
        begin
            next_r.stopped = 1'b1;
            next_r.stopPending = 1'b1;
        end
        if (r.stopPending && !mach.opBusy) next_r.stopPending = 1'b0;
        // Start clears stop and hopper checks, then run-in feeds
        if (cmd[CMD_START])
        begin
            next_r.stopped = cmd[CMD_STOP];
            next_r.priHopChk = 1'b0;
            next_r.secHopChk = 1'b0;
            if (!r.priRdy) next_r.priFeed = RUNIN_PRI_CARDS;
            if (!r.secRdy) next_r.secFeed = RUNIN_SEC_CARDS;
        end
        else
        begin
            if (r.priFeed != 2'h0) next_r.priFeed = r.priFeed - 2'h1;
            if (r.secFeed != 2'h0) next_r.secFeed = r.secFeed - 2'h1;
        end
        // Runout key and check reset; sense after a start clears read/punch
        if (cmd[CMD_RUNOUT])
        begin
            next_r.feedChk = 1'b0;
            next_r.machChk = 1'b0;
        end
        if (cmd[CMD_RUNOUT] || cmd[CMD_CHKRST] || (cmd[CMD_SENSE_RP] && r.sioSeen))
        begin
            next_r.readChk = 1'b0;
            next_r.punchChk = 1'b0;
            next_r.sioSeen = 1'b0;
        end
        if (cmd[CMD_CHKRST]) next_r.noOp = 1'b0;
        if (cmd[CMD_SIO_READ] || cmd[CMD_SIO_PUNCH] || cmd[CMD_SIO_PRINT]) next_r.sioSeen = 1'b1;
        // Print start: accepted always, run only with a card at preprint
        if (cmd[CMD_SIO_PRINT])
        begin
            next_r.print = mach.prePrint;
            if (!mach.prePrint) next_r.noOp = 1'b1;
        end
        // Sticky checks: set wins over any clear above
        if (fault.feedFault || (fault.attnCause && mach.opBusy)) next_r.feedChk = 1'b1;
        if (fault.machFault) next_r.machChk = 1'b1;
        if (fault.readErr || invalidCode) next_r.readChk = 1'b1;
        if (fault.punchErr) next_r.punchChk = 1'b1;
        if (fault.priMisfeed) next_r.priHopChk = 1'b1;
        if (fault.secMisfeed) next_r.secHopChk = 1'b1;
        next_r.store = invalidCode ? CODE_INVALID_DATA : colData;
        // Ready: set by start, held while allowed, dropped otherwise. Checks are taken as
        // they will stand next cycle: a fault drops ready at once, start clears a hopper check
        chkBlock = next_r.priHopChk || next_r.secHopChk || attention || next_r.feedChk
            || next_r.machChk || next_r.stopped;
        next_r.priRdy = priOk && !chkBlock && (r.priRdy || cmd[CMD_START]);
        next_r.secRdy = secOk && !chkBlock && (r.secRdy || cmd[CMD_START]);
        if (cmd[CMD_STOP])
        begin
            next_r.priRdy = 1'b0;
            next_r.secRdy = 1'b0;
        end
        // Interrupt on either feed turning ready
        next_r.irq = r.intEn && ((next_r.priRdy && !r.priRdy) || (next_r.secRdy && !r.secRdy));
        // Register reads
        if (rdStb)
        begin
            unique case (addr)
                ADDR_CTRL: next_r.rd = {7'h00, r.intEn};
                ADDR_STATUS: next_r.rd = {r.stopPending, sum, attention, r.stopped,
                    r.secHopChk, r.priHopChk, r.secRdy, r.priRdy};
                ADDR_SENSE: next_r.rd = {2'h0, r.noOp, r.sioSeen, r.punchChk, r.readChk,
                    r.machChk, r.feedChk};
                default: next_r.rd = 8'h00;
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n) r <= '0;
        else r <= next_r;
    end

    assign rdData = r.rd;
    assign priReady = r.priRdy;
    assign secReady = r.secRdy;
    assign ioCheck = sum;
    assign irqReq = r.irq;
    assign printGo = r.print;
    assign storeData = r.store;
    assign machineHalt = r.stopped && !r.stopPending;
    assign priFeedCount = r.priFeed;
    assign secFeedCount = r.secFeed;

    // ========================================================
    // Checks
    property p_attn_drops;
        @(posedge clk) disable iff (!arst_n) attention |=> !priReady && !secReady;
    endproperty
    a_attn_drops: assert property (p_attn_drops) else $error("ready during attention");

    property p_feed_sum;
        @(posedge clk) disable iff (!arst_n) fault.feedFault |=> ioCheck && !priReady;
    endproperty
    a_feed_sum: assert property (p_feed_sum) else $error("feed check missed");

    property p_mach;
        @(posedge clk) disable iff (!arst_n) fault.machFault |=> ioCheck ##1 !secReady;
    endproperty
    a_mach: assert property (p_mach) else $error("machine check missed");

    property p_inv;
        @(posedge clk) disable iff (!arst_n) invalidCode |=> storeData == 8'h00 && ioCheck;
    endproperty
    a_inv: assert property (p_inv) else $error("invalid code not zeroed");

    property p_irq;
        @(posedge clk) disable iff (!arst_n) irqReq |-> $rose(priReady) || $rose(secReady);
    endproperty
    a_irq: assert property (p_irq) else $error("stray interrupt");

    property p_irq_pulse;
        @(posedge clk) disable iff (!arst_n) irqReq |=> !irqReq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not single");

    property p_stop;
        @(posedge clk) disable iff (!arst_n)
            (cmdStrobe && wrData[CMD_STOP]) |=> !priReady && !secReady;
    endproperty
    a_stop: assert property (p_stop) else $error("stop kept ready");

    property p_noprint;
        @(posedge clk) disable iff (!arst_n)
            (cmdStrobe && wrData[CMD_SIO_PRINT] && !mach.prePrint) |=> !printGo;
    endproperty
    a_noprint: assert property (p_noprint) else $error("print without card");

    // A start right after the misfeed may legally restore ready one cycle later
    property p_misfeed;
        @(posedge clk) disable iff (!arst_n)
            fault.priMisfeed |=> !priReady ##1 (!priReady || $past(cmd[CMD_START]));
    endproperty
    a_misfeed: assert property (p_misfeed) else $error("hopper check ignored");

    // Attention lights the summary check in the same cycle
    property p_attn_sum;
        @(posedge clk) disable iff (!arst_n)
            attention |-> ioCheck;
    endproperty
    a_attn_sum: assert property (p_attn_sum) else $error("attention without check");

    // Feed check drops the secondary feed as well
    property p_feed_sec;
        @(posedge clk) disable iff (!arst_n)
            fault.feedFault |=> !secReady;
    endproperty
    a_feed_sec: assert property (p_feed_sec) else $error("secondary kept ready");

    // Punch error lights the summary check
    property p_punch_sum;
        @(posedge clk) disable iff (!arst_n)
            fault.punchErr |=> ioCheck;
    endproperty
    a_punch_sum: assert property (p_punch_sum) else $error("punch check missed");

    // Read error latches the read check
    property p_read_set;
        @(posedge clk) disable iff (!arst_n)
            fault.readErr |=> r.readChk;
    endproperty
    a_read_set: assert property (p_read_set) else $error("read check missed");

    // Print start with a card waiting moves it through the print station
    property p_print_go;
        @(posedge clk) disable iff (!arst_n)
            (cmd[CMD_SIO_PRINT] && mach.prePrint) |=> printGo;
    endproperty
    a_print_go: assert property (p_print_go) else $error("print not started");

    // Valid columns pass through unchanged
    property p_store;
        @(posedge clk) disable iff (!arst_n)
            !invalidCode |=> storeData == $past(colData);
    endproperty
    a_store: assert property (p_store) else $error("column data altered");

    // Blank is always printable
    property p_blank;
        @(posedge clk) disable iff (!arst_n)
            printChar == CODE_BLANK |-> printCharOk;
    endproperty
    a_blank: assert property (p_blank) else $error("blank refused");

    // All ten digits are printable
    property p_digit;
        @(posedge clk) disable iff (!arst_n)
            (printChar >= CODE_DIGIT_LO && printChar <= CODE_DIGIT_HI) |-> printCharOk;
    endproperty
    a_digit: assert property (p_digit) else $error("digit refused");

    // Codes below the blank carry no symbol
    property p_low_code;
        @(posedge clk) disable iff (!arst_n)
            printChar[7:6] == 2'b00 |-> !printCharOk;
    endproperty
    a_low_code: assert property (p_low_code) else $error("low code accepted");

    // A print start without a card sets the no-op bit, which lights the summary check
    property p_noop_sum;
        @(posedge clk) disable iff (!arst_n)
            (cmd[CMD_SIO_PRINT] && !mach.prePrint) |=> ioCheck;
    endproperty
    a_noop_sum: assert property (p_noop_sum) else $error("no-op not flagged");

    // Secondary hopper misfeed lights the summary check and drops the feed
    property p_sec_hop;
        @(posedge clk) disable iff (!arst_n)
            fault.secMisfeed |=> ioCheck && !secReady;
    endproperty
    a_sec_hop: assert property (p_sec_hop) else $error("hopper check missed");

    // No power, no ready
    property p_power;
        @(posedge clk) disable iff (!arst_n)
            !mach.powerOn |=> !priReady && !secReady;
    endproperty
    a_power: assert property (p_power) else $error("ready without power");

    // Only a start makes the primary feed ready
    property p_pri_start;
        @(posedge clk) disable iff (!arst_n)
            (!priReady && !cmd[CMD_START]) |=> !priReady;
    endproperty
    a_pri_start: assert property (p_pri_start) else $error("primary ready uninvited");

    // Only a start makes the secondary feed ready
    property p_sec_start;
        @(posedge clk) disable iff (!arst_n)
            (!secReady && !cmd[CMD_START]) |=> !secReady;
    endproperty
    a_sec_start: assert property (p_sec_start) else $error("secondary ready uninvited");

    // A stop during a running operation does not halt at once
    property p_halt;
        @(posedge clk) disable iff (!arst_n)
            (cmd[CMD_STOP] && mach.opBusy) |=> !machineHalt;
    endproperty
    a_halt: assert property (p_halt) else $error("halted mid operation");

    // Every ready rise with interrupts enabled gives a request
    property p_irq_rise;
        @(posedge clk) disable iff (!arst_n)
            (($rose(priReady) || $rose(secReady)) && $past(r.intEn)) |-> irqReq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt missed");

    // Runout clears read and punch checks unless a new error lands
    property p_runout;
        @(posedge clk) disable iff (!arst_n)
            (cmd[CMD_RUNOUT] && !fault.readErr && !fault.punchErr && !invalidCode)
            |=> !r.readChk && !r.punchChk;
    endproperty
    a_runout: assert property (p_runout) else $error("runout kept checks");

    // Run-in count steps down one card per cycle
    property p_feed_count;
        @(posedge clk) disable iff (!arst_n)
            (priFeedCount != 2'h0 && !cmd[CMD_START])
            |=> priFeedCount == $past(priFeedCount) - 2'h1;
    endproperty
    a_feed_count: assert property (p_feed_count) else $error("run-in count skipped");
endmodule
